// file: rtl/status_srq.sv
module status_srq
  import status_srq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Internal state from the measurement engine, same clock.
  input wire logic settling,
  input wire logic ranging,
  input wire logic measuring,
  input wire logic trigger_ready,
  input wire logic correction_running,
  input wire logic first_data_buffer_full,
  input wire logic second_data_buffer_full,
  input wire logic output_queue_busy,
  // Error and completion pulses from the command parser.
  input wire logic syntax_error,
  input wire logic trigger_in_message,
  input wire logic param_error,
  input wire logic error_queue_full,
  input wire logic query_empty,
  input wire logic output_lost,
  input wire logic ops_complete,
  // Controller actions.
  input wire logic serial_poll,
  input wire logic clear_status,
  input wire logic esr_read,
  input wire logic oper_event_read,
  input wire logic sre_write,
  input wire logic [7:0] sre_data,
  input wire logic ese_write,
  input wire logic [7:0] ese_data,
  input wire logic oper_enable_write,
  input wire logic [15:0] oper_enable_data,
  input wire logic ques_enable_write,
  input wire logic [15:0] ques_enable_data,
  // Register views.
  output logic srq,
  output logic [7:0] status_summary_byte,
  output logic [7:0] standard_event_flags,
  output logic [7:0] event_enable,
  output logic [7:0] request_enable,
  output logic [15:0] operation_condition,
  output logic [15:0] operation_event,
  output logic [15:0] operation_enable,
  output logic [15:0] questionable_condition,
  output logic [15:0] questionable_event,
  output logic [15:0] questionable_enable
);

  // ==========================================================================
  // Enable masks.
  logic [7:0] sre_q;
  logic [7:0] sre_d;
  logic [7:0] ese_q;
  logic [7:0] ese_d;
  logic [15:0] oen_q;
  logic [15:0] oen_d;

  always_comb begin
    sre_d = sre_q;
    ese_d = ese_q;
    oen_d = oen_q;
    if (sre_write) begin
      sre_d = sre_data & SRE_WRITABLE;
    end
    if (ese_write) begin
      ese_d = ese_data & ESR_USED;
    end
    if (oper_enable_write) begin
      oen_d = oper_enable_data & OPER_USED;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sre_q <= ZERO8;
      ese_q <= ZERO8;
      oen_q <= ZERO16;
    end else if (clk_en) begin
      sre_q <= sre_d;
      ese_q <= ese_d;
      oen_q <= oen_d;
    end
  end

  // ==========================================================================
  // Operation condition and event registers.
  logic [15:0] cond_now;
  logic [15:0] cond_q;
  logic [15:0] cond_d;
  logic [15:0] oev_q;
  logic [15:0] oev_d;
  logic [15:0] oper_hits;

  always_comb begin
    cond_now = ZERO16;
    cond_now[OPER_SET_BIT] = settling;
    cond_now[OPER_RANGE_BIT] = ranging;
    cond_now[OPER_MEAS_BIT] = measuring;
    cond_now[OPER_TRIG_BIT] = trigger_ready;
    cond_now[OPER_CORR_BIT] = correction_running;
    cond_now[OPER_FIRST_DATA_BUFFER_BIT] = first_data_buffer_full;
    cond_now[OPER_SECOND_DATA_BUFFER_BIT] = second_data_buffer_full;
  end

  // Completion bits catch falling edges; buffer fullness catches rising ones.
  assign oper_hits = ((cond_q & ~cond_now) & ~OPER_RISE_SEL)
                   | ((~cond_q & cond_now) & OPER_RISE_SEL);

  always_comb begin
    cond_d = cond_now;
    oev_d = oev_q;
    if (oper_event_read || clear_status) begin
      oev_d = ZERO16;
    end
    // A new edge in the cycle of a clear is kept.
    oev_d = oev_d | (oper_hits & OPER_USED);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= ZERO16;
      oev_q <= ZERO16;
    end else if (clk_en) begin
      cond_q <= cond_d;
      oev_q <= oev_d;
    end
  end

  // ==========================================================================
  // Standard event register.
  logic [7:0] esr_q;
  logic [7:0] esr_d;
  logic [7:0] esr_hits;

  always_comb begin
    esr_hits = ZERO8;
    esr_hits[ESR_CME_BIT] = syntax_error | trigger_in_message;
    esr_hits[ESR_EXE_BIT] = param_error;
    esr_hits[ESR_DDE_BIT] = error_queue_full;
    esr_hits[ESR_QYE_BIT] = query_empty | output_lost;
    esr_hits[ESR_OPC_BIT] = ops_complete;
    esr_d = esr_q;
    if (esr_read || clear_status) begin
      esr_d = ZERO8;
    end
    esr_d = (esr_d | esr_hits) & ESR_USED;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      esr_q <= ESR_RESET;
    end else if (clk_en) begin
      esr_q <= esr_d;
    end
  end

  // ==========================================================================
  // Status byte and service request.
  logic oper_sum;
  logic esr_sum;
  logic ques_sum;
  logic [7:0] stb_base;
  logic any_enabled;
  logic any_enabled_q;
  logic any_enabled_d;
  logic rqs_q;
  logic rqs_d;

  assign oper_sum = |(oev_q & oen_q);
  assign esr_sum = |(esr_q & ese_q);
  assign ques_sum = 1'b0;

  always_comb begin
    stb_base = ZERO8;
    stb_base[STB_OPER_BIT] = oper_sum;
    stb_base[STB_ESR_BIT] = esr_sum;
    stb_base[STB_MAV_BIT] = output_queue_busy;
    stb_base[STB_QUES_BIT] = ques_sum;
  end

  assign any_enabled = |(stb_base & sre_q);

  always_comb begin
    any_enabled_d = any_enabled;
    rqs_d = rqs_q;
    if (serial_poll || clear_status) begin
      rqs_d = 1'b0;
    end
    // A fresh enabled reason sets the flag even during a poll.
    if (any_enabled && !any_enabled_q) begin
      rqs_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      any_enabled_q <= 1'b0;
      rqs_q <= 1'b0;
    end else if (clk_en) begin
      any_enabled_q <= any_enabled_d;
      rqs_q <= rqs_d;
    end
  end

  // ==========================================================================
  // Registered views of the status byte.
  logic [7:0] stb_q;
  logic [7:0] stb_d;

  always_comb begin
    stb_d = stb_base;
    stb_d[STB_RQS_BIT] = rqs_d;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stb_q <= ZERO8;
    end else if (clk_en) begin
      stb_q <= stb_d;
    end
  end

  assign srq = stb_q[STB_RQS_BIT];
  assign status_summary_byte = stb_q;
  assign standard_event_flags = esr_q;
  assign event_enable = ese_q;
  assign request_enable = sre_q;
  assign operation_condition = cond_q;
  assign operation_event = oev_q;
  assign operation_enable = oen_q;
  // The questionable group exists but never reports anything.
  assign questionable_condition = ZERO16;
  assign questionable_event = ZERO16;
  assign questionable_enable = ZERO16;

  // Writes to the questionable mask are accepted and discarded.
  logic ques_unused;
  assign ques_unused = ques_enable_write & (|ques_enable_data);

endmodule : status_srq

// file: shared/status_srq_pkg.sv
// Contract
// - Enable mask selects which summaries request service
// - Status byte has four summary bits and a request bit
// - Reads return the weighted sum of set bits
// - Status bit 7 summarizes operation group
// - Request flag set by enabled bit, cleared by poll
// - Status bit 5 summarizes standard event register
// - Status bit 4 follows output queue data present
// - Bit 3 questionable summary, bits 2-0 zero
// - Event bit 7 flags power cycle since read
// - Event bit 5 flags syntax error or trigger
// - Event bit 4 flags out-of-range parameter
// - Event bit 3 flags full error queue
// - Event bit 2 flags empty read or loss
// - Event bit 0 flags pending operations complete
// - Querying standard event register clears it
// - Both groups hold condition, event, enable registers; only the operation group has them here, questionable views are tied to ZERO16
// - Condition bits follow the current internal state
// - Falling edge sets events, rising for 8, 9
// - Enable bits gate events into group summary
// - Operation condition bit meanings; others read zero
// - Operation events record completions and fullness
// - Questionable group always reads zero
package status_srq_pkg;

  // ==========================================================================
  // Status byte layout.
  localparam int unsigned STB_OPER_BIT = 7;
  localparam int unsigned STB_RQS_BIT = 6;
  localparam int unsigned STB_ESR_BIT = 5;
  localparam int unsigned STB_MAV_BIT = 4;
  localparam int unsigned STB_QUES_BIT = 3;
  localparam logic [7:0] SRE_WRITABLE = 8'hBF;

  // ==========================================================================
  // Standard event layout.
  localparam int unsigned ESR_PON_BIT = 7;
  localparam int unsigned ESR_CME_BIT = 5;
  localparam int unsigned ESR_EXE_BIT = 4;
  localparam int unsigned ESR_DDE_BIT = 3;
  localparam int unsigned ESR_QYE_BIT = 2;
  localparam int unsigned ESR_OPC_BIT = 0;
  localparam logic [7:0] ESR_RESET = 8'h80;
  localparam logic [7:0] ESR_USED = 8'hBD;

  // ==========================================================================
  // Operation group layout.
  localparam int unsigned OPER_W = 16;
  localparam int unsigned OPER_SET_BIT = 1;
  localparam int unsigned OPER_RANGE_BIT = 2;
  localparam int unsigned OPER_MEAS_BIT = 4;
  localparam int unsigned OPER_TRIG_BIT = 5;
  localparam int unsigned OPER_CORR_BIT = 7;
  localparam int unsigned OPER_FIRST_DATA_BUFFER_BIT = 8;
  localparam int unsigned OPER_SECOND_DATA_BUFFER_BIT = 9;
  localparam logic [15:0] OPER_USED = 16'h03B6;
  localparam logic [15:0] OPER_RISE_SEL = 16'h0300;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;

endpackage : status_srq_pkg

// file: sim/gpib_ctrl_model.sv
module gpib_ctrl_model (
  input wire logic sys_clk,
  input wire logic srq,
  input wire logic poll_en,
  output logic serial_poll
);
  timeunit 1ns;
  timeprecision 1ns;
  // ======
  // Answers a service request with one serial poll, two cycles late.
  initial begin
    serial_poll = 1'b0;
    forever begin
      @(negedge sys_clk);
      if (poll_en && srq === 1'b1) begin
        repeat (2) @(negedge sys_clk);
        serial_poll = 1'b1;
        @(negedge sys_clk);
        serial_poll = 1'b0;
      end
    end
  end
endmodule : gpib_ctrl_model

// file: sim/status_srq_props.sv
module status_srq_props
  import status_srq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic output_queue_busy,
  input wire logic esr_read,
  input wire logic syntax_error,
  input wire logic trigger_in_message,
  input wire logic param_error,
  input wire logic error_queue_full,
  input wire logic query_empty,
  input wire logic output_lost,
  input wire logic ops_complete,
  input wire logic sre_write,
  input wire logic [7:0] sre_data,
  input wire logic srq,
  input wire logic [7:0] status_summary_byte,
  input wire logic [7:0] standard_event_flags,
  input wire logic [7:0] request_enable,
  input wire logic [15:0] operation_condition,
  input wire logic [15:0] operation_event,
  input wire logic [15:0] questionable_event
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ev_any;
  assign ev_any = syntax_error | trigger_in_message | param_error | error_queue_full
    | query_empty | output_lost | ops_complete;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ======
  // Properties.
  sequence s_fell4; $fell(operation_condition[OPER_MEAS_BIT]); endsequence
  sequence s_rose8; $rose(operation_condition[OPER_FIRST_DATA_BUFFER_BIT]); endsequence
  property p_srq; srq == status_summary_byte[STB_RQS_BIT]; endproperty
  property p_low; status_summary_byte[2:0] == 3'h0; endproperty
  property p_esr_res; (standard_event_flags & 8'h42) == ZERO8; endproperty
  property p_ques; questionable_event == ZERO16; endproperty
  property p_oper; ((operation_condition | operation_event) & ~OPER_USED) == ZERO16; endproperty
  property p_mav; $past(clk_en) |-> status_summary_byte[4] == $past(output_queue_busy); endproperty
  property p_esr_clr; esr_read && clk_en && !ev_any |=> standard_event_flags == ZERO8; endproperty
  property p_sre; sre_write && clk_en |=> request_enable == (sre_data & SRE_WRITABLE); endproperty
  property p_fall; s_fell4 |-> ##[0:1] operation_event[OPER_MEAS_BIT]; endproperty
  property p_rise; s_rose8 |-> ##[0:1] operation_event[OPER_FIRST_DATA_BUFFER_BIT]; endproperty
  a_srq: assert property (p_srq) else $error("srq differs from flag.");
  a_low: assert property (p_low) else $error("low status bits set.");
  a_esr_res: assert property (p_esr_res) else $error("reserved event bit set.");
  a_ques: assert property (p_ques) else $error("questionable event set.");
  a_oper: assert property (p_oper) else $error("unused operation bit set.");
  a_mav: assert property (p_mav) else $error("queue bit wrong.");
  a_esr_clr: assert property (p_esr_clr) else $error("event read no clear.");
  a_sre: assert property (p_sre) else $error("request mask wrong.");
  a_fall: assert property (p_fall) else $error("falling event missed.");
  a_rise: assert property (p_rise) else $error("rising event missed.");
endmodule : status_srq_props

bind status_srq status_srq_props i_props (.*);

// file: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, arst_n, clk_en, busy, serial_poll, clear_status, esr_read, oper_event_read;
  logic sre_write, ese_write, oper_enable_write, ques_enable_write, srq, poll_en;
  logic [6:0] ev, cond;
  logic [7:0] sre_data, ese_data, stb, esr, ese, sre;
  logic [15:0] oen_d, qen_d, ocond, oev, oen, qcond, qev, qen;
  logic [7:0] ev_exp [7] = '{8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h01};
  int n_mismatch = 0;
  int tests_run = 0;
  // ======
  // Design and far side.
  status_srq i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
    .settling(cond[0]), .ranging(cond[1]), .measuring(cond[2]), .trigger_ready(cond[3]),
    .correction_running(cond[4]), .first_data_buffer_full(cond[5]),
    .second_data_buffer_full(cond[6]), .output_queue_busy(busy),
    .syntax_error(ev[0]), .trigger_in_message(ev[1]), .param_error(ev[2]),
    .error_queue_full(ev[3]), .query_empty(ev[4]), .output_lost(ev[5]),
    .ops_complete(ev[6]), .serial_poll(serial_poll), .clear_status(clear_status),
    .esr_read(esr_read), .oper_event_read(oper_event_read), .sre_write(sre_write),
    .sre_data(sre_data), .ese_write(ese_write), .ese_data(ese_data),
    .oper_enable_write(oper_enable_write), .oper_enable_data(oen_d),
    .ques_enable_write(ques_enable_write), .ques_enable_data(qen_d), .srq(srq),
    .status_summary_byte(stb), .standard_event_flags(esr), .event_enable(ese),
    .request_enable(sre), .operation_condition(ocond), .operation_event(oev),
    .operation_enable(oen), .questionable_condition(qcond), .questionable_event(qev),
    .questionable_enable(qen));
  gpib_ctrl_model i_ctrl (.sys_clk(sys_clk), .srq(srq), .poll_en(poll_en),
    .serial_poll(serial_poll));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic read_esr();
    esr_read = 1'b1;
    step(1);
    esr_read = 1'b0;
    step(3);
  endtask : read_esr
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    give_verdict();
  end
  // ======
  // Tests.
  initial begin
    {arst_n, busy, clear_status, esr_read, oper_event_read, sre_write, ese_write} = '0;
    {oper_enable_write, ques_enable_write, poll_en, ev, cond, sre_data, ese_data} = '0;
    {oen_d, qen_d} = '0;
    clk_en = 1'b1;
    step(4);
    arst_n = 1'b1;
    step(1);
    check("esr reset", 16'(esr), 16'h0080);
    check("stb reset", 16'(stb), 16'h0000);
    read_esr();
    for (int i = 0; i < 7; i++) begin
      ev = 7'(1 << i);
      step(1);
      ev = '0;
      step(3);
      check("esr event", 16'(esr), 16'(ev_exp[i]));
      read_esr();
      check("esr clear", 16'(esr), 16'h0000);
    end
    {ese_data, sre_data, oen_d, qen_d} = '1;
    {ese_write, sre_write, oper_enable_write, ques_enable_write} = '1;
    step(1);
    {ese_write, sre_write, oper_enable_write, ques_enable_write} = '0;
    check("sre", 16'(sre), 16'h00BF);
    check("ese", 16'(ese), 16'h00BD);
    check("oper en", oen, 16'h03B6);
    check("ques", qen | qcond, 16'h0000);
    ev = 7'h01;
    busy = 1'b1;
    step(1);
    ev = '0;
    step(3);
    check("stb request", 16'(stb), 16'h0070);
    check("srq", 16'(srq), 16'h0001);
    poll_en = 1'b1;
    step(6);
    check("stb poll", 16'(stb), 16'h0030);
    busy = 1'b0;
    read_esr();
    check("stb clear", 16'(stb), 16'h0000);
    cond = '1;
    step(3);
    check("oper cond", ocond, 16'h03B6);
    check("oper rise", oev, 16'h0300);
    cond = '0;
    step(3);
    check("oper event", oev, 16'h03B6);
    check("oper sum", 16'(stb[7]), 16'h0001);
    oper_event_read = 1'b1;
    step(1);
    oper_event_read = 1'b0;
    step(6);
    check("oper read", oev, 16'h0000);
    check("stb idle", 16'(stb), 16'h0000);
    clk_en = 1'b0;
    ev = 7'h01;
    step(1);
    ev = '0;
    clk_en = 1'b1;
    step(3);
    check("esr frozen", 16'(esr), 16'h0000);
    ev = 7'h40;
    step(1);
    ev = '0;
    step(2);
    check("esr complete", 16'(esr), 16'h0001);
    clear_status = 1'b1;
    step(1);
    clear_status = 1'b0;
    step(3);
    check("esr cleared", 16'(esr), 16'h0000);
    check("stb cleared", 16'(stb), 16'h0000);
    check("ques event", qev, 16'h0000);
    arst_n = 1'b0;
    step(1);
    arst_n = 1'b1;
    step(1);
    check("esr power on", 16'(esr), 16'h0080);
    give_verdict();
  end
endmodule : testbench
